// >>> verilog/uam_pkg.sv
package uam_pkg;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_CTL0 = 14'h0F42;
  localparam logic [13:0] IDX_CTL1 = 14'h0F43;
  localparam logic [13:0] IDX_ADDR = 14'h0F45;
  localparam logic [13:0] IDX_BRH  = 14'h0F46;
  localparam logic [13:0] IDX_BRL  = 14'h0F47;
  localparam logic [13:0] IDX_RXD  = 14'h0F48;
  localparam logic [13:0] IDX_STAT = 14'h0F49;
  localparam logic [13:0] IDX_TXD  = 14'h0F4A;

  // Control zero fields
  localparam int CTL0_TEN  = 7;
  localparam int CTL0_REN  = 6;
  localparam int CTL0_CTS_GATE_ENABLE = 5;
  localparam int CTL0_PEN  = 4;
  localparam int CTL0_PSEL = 3;
  localparam int CTL0_SEND_BREAK = 2;
  localparam int CTL0_STOP = 1;
  localparam int CTL0_LOOPBACK = 0;

  // Control one fields
  localparam int CTL1_MULTINODE_MODE_ENABLE    = 7;
  localparam int CTL1_ADDRESS_MATCH_SCHEME_HI = 6;
  localparam int CTL1_ADDRESS_MATCH_SCHEME_LO = 5;
  localparam int CTL1_ERRONLY = 4;
  localparam int CTL1_TXBIT9  = 0;

  // Status fields
  localparam int STAT_RDA    = 0;
  localparam int STAT_PE     = 1;
  localparam int STAT_OE     = 2;
  localparam int STAT_FE     = 3;
  localparam int STAT_TXE    = 4;
  localparam int STAT_TXIDLE = 5;
  localparam int STAT_CTS    = 6;
  localparam int STAT_RXBIT9 = 7;

  // Reset values
  localparam logic [7:0]  CTL0_RST = 8'h00;
  localparam logic [7:0]  CTL1_RST = 8'h00;
  localparam logic [7:0]  ADDR_RST = 8'h00;
  localparam logic [15:0] BRG_RST  = 16'hFFFF;

  // Sixteen baud ticks per bit, sampled in the middle
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] PH_MID  = 4'h7;

  // Data bits per character, after the start bit
  localparam logic [3:0] DATA_BITS = 4'h8;

endpackage

// >>> verilog/uam_baud_gen.sv
`timescale 1ns/10ps
module uam_baud_gen (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] divisor,
  output logic             tick
);

  logic [15:0] cnt_r;

  // Divisor of zero or one gives a tick every cycle
  // Restart when the divisor drops below the count, so a new rate applies at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_r <= 16'h0001 || cnt_r > divisor) begin
      cnt_r <= divisor;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule

// >>> verilog/uam_uart.sv
// Operation
// - Eight data bits per character, least significant bit first on the line.
// - One low start bit; one or two high stop bits end the character.
// - Outside multinode mode, parity enable adds a parity bit on transmit and expects one on receive.
// - Parity select: zero even, one odd, for both directions.
// - Transmit enable turns the transmitter on; with gating, only while CTS is low.
// - Gating bit clear ignores CTS; set makes CTS an extra transmit enable.
// - Receive enable turns the receiver on or off.
// - Send break forces the line low and aborts the character in progress.
// - Receive interrupt on new character available and on receive errors.
// - Multinode enable selects 9-bit format; two-bit scheme picks address matching.
// - Receive interrupt either for data plus errors or for errors only.
// - Upper scheme bit: address characters compared to node address; data only on match.
// - Baud rate set by a 16-bit divisor from high and low byte registers.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module uam_uart (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output logic             txd,
  output logic             rx_irq,
  output logic             rx_data_available
);

  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} uam_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_DONE} uam_rx_st_t;

  logic [7:0]  ctl0_r;
  logic [7:0]  ctl1_r;
  logic [7:0]  node_addr_r;
  logic [15:0] baud_divisor_r;
  logic        tick;

  logic        setup_ph;
  logic        access_ph;
  logic        wr_en;
  logic        rd_rxd;
  logic [13:0] idx;
  logic        mapped;
  logic [7:0]  status;

  // Transmit side
  uam_tx_st_t  tx_st_r;
  logic [7:0]  tx_hold_r;
  logic        tx_full_r;
  logic [11:0] tx_sh_r;
  logic [3:0]  tx_left_r;
  logic [3:0]  tx_ph_r;
  logic        tx_go;
  logic        tx_line;
  logic        tx_extra;
  logic [11:0] tx_frame;
  logic [3:0]  tx_count;

  // Receive side
  uam_rx_st_t  rx_st_r;
  logic [3:0]  rx_ph_r;
  logic [3:0]  rx_cnt_r;
  logic [11:0] rx_bits_r;
  logic        rx_in;
  logic [3:0]  rx_total;
  logic [7:0]  rx_data_r;
  logic        rx_bit9_r;
  logic        rda_r;
  logic        pe_r;
  logic        fe_r;
  logic        oe_r;
  logic        selected_r;
  logic        deliver;
  logic        frame_err;
  logic        par_err;
  logic        addr_match;

  logic        multinode_mode_enable;
  logic        has_extra;
  logic        two_stop;

  assign multinode_mode_enable      = ctl1_r[uam_pkg::CTL1_MULTINODE_MODE_ENABLE];
  assign has_extra = multinode_mode_enable | ctl0_r[uam_pkg::CTL0_PEN];
  assign two_stop  = ctl0_r[uam_pkg::CTL0_STOP];

  uam_baud_gen u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (baud_divisor_r),
    .tick    (tick)
  );

  // APB decode; zero wait states, answer in the access cycle
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign idx       = paddr[15:2];
  assign wr_en     = access_ph & pwrite;
  assign rd_rxd    = access_ph & ~pwrite & (idx == uam_pkg::IDX_RXD);
  assign mapped    = (idx == uam_pkg::IDX_CTL0) | (idx == uam_pkg::IDX_CTL1) |
                     (idx == uam_pkg::IDX_ADDR) | (idx == uam_pkg::IDX_BRH) |
                     (idx == uam_pkg::IDX_BRL) | (idx == uam_pkg::IDX_RXD) |
                     (idx == uam_pkg::IDX_STAT) | (idx == uam_pkg::IDX_TXD);

  always_comb begin
    status = 8'h00;
    status[uam_pkg::STAT_RDA]    = rda_r;
    status[uam_pkg::STAT_PE]     = pe_r;
    status[uam_pkg::STAT_OE]     = oe_r;
    status[uam_pkg::STAT_FE]     = fe_r;
    status[uam_pkg::STAT_TXE]    = ~tx_full_r;
    status[uam_pkg::STAT_TXIDLE] = ~tx_full_r & (tx_st_r == TX_IDLE);
    status[uam_pkg::STAT_CTS]    = cts_n;
    status[uam_pkg::STAT_RXBIT9] = rx_bit9_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_ph) begin
        pslverr <= ~mapped;
        prdata  <= 32'h0000_0000;
        if (!pwrite) begin
          unique case (1'b1)
            idx == uam_pkg::IDX_CTL0: prdata[7:0] <= ctl0_r;
            idx == uam_pkg::IDX_CTL1: prdata[7:0] <= ctl1_r;
            idx == uam_pkg::IDX_ADDR: prdata[7:0] <= node_addr_r;
            idx == uam_pkg::IDX_BRH:  prdata[7:0] <= baud_divisor_r[15:8];
            idx == uam_pkg::IDX_BRL:  prdata[7:0] <= baud_divisor_r[7:0];
            idx == uam_pkg::IDX_RXD:  prdata[7:0] <= rx_data_r;
            idx == uam_pkg::IDX_STAT: prdata[7:0] <= status;
            default:                  prdata[7:0] <= 8'h00;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_r         <= uam_pkg::CTL0_RST;
      ctl1_r         <= uam_pkg::CTL1_RST;
      node_addr_r    <= uam_pkg::ADDR_RST;
      baud_divisor_r <= uam_pkg::BRG_RST;
    end else if (wr_en) begin
      if (idx == uam_pkg::IDX_CTL0) ctl0_r <= pwdata[7:0];
      if (idx == uam_pkg::IDX_CTL1) ctl1_r <= pwdata[7:0];
      if (idx == uam_pkg::IDX_ADDR) node_addr_r <= pwdata[7:0];
      if (idx == uam_pkg::IDX_BRH)  baud_divisor_r[15:8] <= pwdata[7:0];
      if (idx == uam_pkg::IDX_BRL)  baud_divisor_r[7:0] <= pwdata[7:0];
    end
  end

  // Transmit frame, lsb first: start, data, parity or address bit, stops
  assign tx_go    = ctl0_r[uam_pkg::CTL0_TEN] &
                    (~ctl0_r[uam_pkg::CTL0_CTS_GATE_ENABLE] | ~cts_n);
  assign tx_extra = multinode_mode_enable ? ctl1_r[uam_pkg::CTL1_TXBIT9] :
                    (^tx_hold_r) ^ ctl0_r[uam_pkg::CTL0_PSEL];

  always_comb begin
    if (has_extra) begin
      tx_frame = {2'b11, tx_extra, tx_hold_r, 1'b0};
      tx_count = 4'hB;
    end else begin
      tx_frame = {3'b111, tx_hold_r, 1'b0};
      tx_count = 4'hA;
    end
    if (two_stop) begin
      tx_count = tx_count + 4'h1;
    end
  end

  // Holding register; a write while full is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_r <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (wr_en && idx == uam_pkg::IDX_TXD && !tx_full_r) begin
      tx_hold_r <= pwdata[7:0];
      tx_full_r <= 1'b1;
    end else if (tx_st_r == TX_IDLE && tx_full_r && tx_go && tick &&
                 !ctl0_r[uam_pkg::CTL0_SEND_BREAK]) begin
      tx_full_r <= 1'b0;
    end
  end

  // Gating only holds off the next start; a character underway completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r   <= TX_IDLE;
      tx_sh_r   <= 12'hFFF;
      tx_left_r <= 4'h0;
      tx_ph_r   <= 4'h0;
    end else if (ctl0_r[uam_pkg::CTL0_SEND_BREAK]) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 12'hFFF;
      tx_ph_r <= 4'h0;
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          if (tx_full_r && tx_go && tick) begin
            tx_st_r   <= TX_SHIFT;
            tx_sh_r   <= tx_frame;
            tx_left_r <= tx_count;
            tx_ph_r   <= 4'h0;
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            tx_ph_r <= tx_ph_r + 4'h1;
            if (tx_ph_r == uam_pkg::PH_LAST) begin
              tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
              tx_left_r <= tx_left_r - 4'h1;
              if (tx_left_r == 4'h1) begin
                tx_st_r <= TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  assign tx_line = ctl0_r[uam_pkg::CTL0_SEND_BREAK] ? 1'b0 :
                   ((tx_st_r == TX_SHIFT) ? tx_sh_r[0] : 1'b1);

  // External line idles high during loopback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
    end else begin
      txd <= ctl0_r[uam_pkg::CTL0_LOOPBACK] ? 1'b1 : tx_line;
    end
  end

  // Receiver, sixteen ticks per bit
  assign rx_in    = ctl0_r[uam_pkg::CTL0_LOOPBACK] ? tx_line : rxd;
  assign rx_total = uam_pkg::DATA_BITS + {3'b000, has_extra} + 4'h1 +
                    {3'b000, two_stop};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r   <= RX_IDLE;
      rx_ph_r   <= 4'h0;
      rx_cnt_r  <= 4'h0;
      rx_bits_r <= 12'h000;
    end else if (!ctl0_r[uam_pkg::CTL0_REN]) begin
      rx_st_r <= RX_IDLE;
    end else begin
      unique case (rx_st_r)
        RX_IDLE: begin
          if (tick && !rx_in) begin
            rx_st_r <= RX_START;
            rx_ph_r <= 4'h0;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_ph_r <= rx_ph_r + 4'h1;
            if (rx_ph_r == uam_pkg::PH_MID) begin
              rx_st_r  <= rx_in ? RX_IDLE : RX_BITS;
              rx_ph_r  <= 4'h0;
              rx_cnt_r <= 4'h0;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_ph_r <= rx_ph_r + 4'h1;
            if (rx_ph_r == uam_pkg::PH_LAST) begin
              rx_bits_r[rx_cnt_r] <= rx_in;
              rx_cnt_r            <= rx_cnt_r + 4'h1;
              if (rx_cnt_r == rx_total - 4'h1) begin
                rx_st_r <= RX_DONE;
              end
            end
          end
        end
        RX_DONE: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // Character checks in the cycle after the last stop bit is sampled at its middle
  always_comb begin
    frame_err = 1'b0;
    if (has_extra) begin
      frame_err = ~rx_bits_r[9] | (two_stop & ~rx_bits_r[10]);
    end else begin
      frame_err = ~rx_bits_r[8] | (two_stop & ~rx_bits_r[9]);
    end
  end

  assign par_err    = ctl0_r[uam_pkg::CTL0_PEN] & ~multinode_mode_enable &
                      ((^rx_bits_r[7:0]) ^ rx_bits_r[8] ^ ctl0_r[uam_pkg::CTL0_PSEL]);
  assign addr_match = rx_bits_r[7:0] == node_addr_r;

  always_comb begin
    deliver = 1'b0;
    if (rx_st_r == RX_DONE && ctl0_r[uam_pkg::CTL0_REN]) begin
      if (multinode_mode_enable && ctl1_r[uam_pkg::CTL1_ADDRESS_MATCH_SCHEME_HI]) begin
        if (rx_bits_r[8]) begin
          deliver = addr_match & ~ctl1_r[uam_pkg::CTL1_ADDRESS_MATCH_SCHEME_LO];
        end else begin
          deliver = selected_r;
        end
      end else begin
        deliver = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selected_r <= 1'b0;
    end else if (!multinode_mode_enable) begin
      selected_r <= 1'b0;
    end else if (rx_st_r == RX_DONE && rx_bits_r[8]) begin
      selected_r <= addr_match;
    end
  end

  // Set wins over the clear by a read of the data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_r <= 8'h00;
      rx_bit9_r <= 1'b0;
      rda_r     <= 1'b0;
      pe_r      <= 1'b0;
      fe_r      <= 1'b0;
      oe_r      <= 1'b0;
    end else if (deliver) begin
      rx_data_r <= rx_bits_r[7:0];
      rx_bit9_r <= multinode_mode_enable & rx_bits_r[8];
      rda_r     <= 1'b1;
      pe_r      <= par_err | (pe_r & ~rd_rxd);
      fe_r      <= frame_err | (fe_r & ~rd_rxd);
      oe_r      <= (rda_r & ~rd_rxd) | (oe_r & ~rd_rxd);
    end else if (rd_rxd) begin
      rda_r <= 1'b0;
      pe_r  <= 1'b0;
      fe_r  <= 1'b0;
      oe_r  <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq            <= 1'b0;
      rx_data_available <= 1'b0;
    end else begin
      rx_irq            <= (rda_r & ~ctl1_r[uam_pkg::CTL1_ERRONLY]) | pe_r | fe_r | oe_r;
      rx_data_available <= rda_r;
    end
  end

endmodule

// >>> testbench/uam_uart_chk.sv
`timescale 1ns/10ps
module uam_uart_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cts_n,
  input wire logic        txd,
  input wire logic        rx_irq,
  input wire logic        rx_data_available
);
  logic [13:0] ix;
  logic        wr;
  logic        mapped;
  logic [7:0]  c0_r;
  logic        eo_r;
  logic [7:0]  hi_r;
  assign ix = paddr[15:2];
  assign wr = psel && penable && pwrite && pready;
  // Index F44 is the one hole in the map
  assign mapped = ix >= uam_pkg::IDX_CTL0 && ix <= uam_pkg::IDX_TXD && ix != 14'h0F44;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c0_r <= 8'h00;
    else if (wr && ix == uam_pkg::IDX_CTL0) c0_r <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) eo_r <= 1'b0;
    else if (wr && ix == uam_pkg::IDX_CTL1) eo_r <= pwdata[4];
  end
  // Saturating count of high cycles; 255 is longer than any high run inside a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_r <= 8'h00;
    else if (!txd) hi_r <= 8'h00;
    else if (hi_r != 8'hFF) hi_r <= hi_r + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property ($past(presetn) |-> pready) else $error("pready low");
  AST_SLVERR: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (psel && penable && mapped |-> !pslverr) else $error("mapped access refused");
  AST_PRDATA: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_BREAK: assert property ((c0_r[2] && !c0_r[0]) [*4] |-> !txd) else $error("break not low");
  AST_LOOP: assert property (c0_r[0] [*4] |-> txd) else $error("loopback drives line");
  AST_START: assert property (hi_r == 8'hFF && !txd && !c0_r[2] && !$past(c0_r[2]) |->
    $past(c0_r[7], 2) && (!$past(c0_r[5], 2) || !$past(cts_n, 2))) else $error("start not enabled");
  AST_IRQ: assert property (rx_data_available && !eo_r && !$past(eo_r) |-> rx_irq)
    else $error("no irq on data");
  AST_RXOFF: assert property ((!c0_r[6]) [*5] |-> !$rose(rx_data_available))
    else $error("data while receiver off");
  cover property ($rose(rx_data_available));
  cover property (psel && penable && pslverr);
  cover property (c0_r[2] && !txd);
endmodule
bind uam_uart uam_uart_chk uam_uart_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cts_n(cts_n), .txd(txd), .rx_irq(rx_irq), .rx_data_available(rx_data_available));

// >>> testbench/uam_remote_node.sv
`timescale 1ns/10ps
module uam_remote_node (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n
);
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  // Frame bits lsb first, 16 clocks each at divisor 1
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // Sample mid-bit from the falling start edge
  task automatic grab(output logic [11:0] f, input int n);
    int t;
    f = '1;
    t = 0;
    while (txd !== 1'b0 && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    repeat (8) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (16) @(posedge pclk);
    end
  endtask
endmodule

// >>> testbench/tb_uart_async_multinode.sv
`timescale 1ns/10ps
module tb_uart_async_multinode;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rxd, cts_n, txd, rx_irq, rx_data_available, er, pe, od, tw;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] f, ef;
  logic [7:0]  d;
  int          mismatches, num_checks, cyc, n;
  // Rows: parity enable, odd, two stops, data
  localparam logic [10:0] ROWS [4] = '{11'h001, 11'h5A5, 11'h680, 11'h300};
  uam_uart uam_uart_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .cts_n(cts_n), .txd(txd), .rx_irq(rx_irq), .rx_data_available(rx_data_available));
  uam_remote_node uam_remote_node_inst (.pclk(pclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [13:0] ix, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Enables dropped before any control write
  task cfg(input logic [7:0] c1, input logic [7:0] c0);
    apb(1'b1, uam_pkg::IDX_CTL0, 8'h00);
    apb(1'b1, uam_pkg::IDX_CTL1, c1);
    apb(1'b1, uam_pkg::IDX_CTL0, c0);
  endtask
  function automatic logic [11:0] frame(input logic [7:0] v, input logic xe, input logic x);
    frame = {3'b111, v, 1'b0};
    if (xe) frame[9] = x;
  endfunction
  task rx_get(input logic [7:0] v, input logic [4:0] e);
    int t;
    t = 0;
    while (rx_data_available !== 1'b1 && t < 400) begin
      @(posedge pclk);
      t++;
    end
    apb(1'b0, uam_pkg::IDX_STAT, 8'h00);
    chk({rx_irq, rd[3:0]}, e);
    apb(1'b0, uam_pkg::IDX_RXD, 8'h00);
    chk(rd[7:0], v);
  endtask
  task none;
    repeat (4) @(posedge pclk);
    chk(rx_data_available, 1'b0);
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, uam_pkg::IDX_CTL0, 8'h00);
    chk(rd, 32'h00000000);
    apb(1'b0, uam_pkg::IDX_ADDR, 8'h00);
    chk(rd, 32'h00000000);
    apb(1'b0, uam_pkg::IDX_BRH, 8'h00);
    chk(rd, 32'h000000FF);
    apb(1'b0, uam_pkg::IDX_BRL, 8'h00);
    chk(rd, 32'h000000FF);
    apb(1'b0, 14'h0F44, 8'h00);
    chk({31'h0, er}, 32'h00000001);
    chk(rd, 32'h00000000);
    apb(1'b1, uam_pkg::IDX_BRH, 8'h00);
    apb(1'b1, uam_pkg::IDX_BRL, 8'h01);
    $display("reset and map done");
    foreach (ROWS[k]) begin
      {pe, od, tw, d} = ROWS[k];
      cfg(8'h00, {3'b110, pe, od, 1'b0, tw, 1'b0});
      apb(1'b1, uam_pkg::IDX_TXD, d);
      ef = frame(d, pe, ^d ^ od);
      n = 10 + pe + tw;
      uam_remote_node_inst.grab(f, n);
      chk(f, ef);
      uam_remote_node_inst.send(ef, n);
      rx_get(d, 5'h11);
      $display("row %0d done", k);
    end
    // Transmitter already idle here
    cfg(8'h00, 8'h84);
    repeat (4) @(posedge pclk);
    chk(txd, 1'b0);
    uam_remote_node_inst.cts_n <= 1'b1;
    cfg(8'h00, 8'hA0);
    apb(1'b1, uam_pkg::IDX_TXD, 8'h96);
    repeat (60) @(posedge pclk);
    chk(txd, 1'b1);
    uam_remote_node_inst.cts_n <= 1'b0;
    uam_remote_node_inst.grab(f, 10);
    chk(f, frame(8'h96, 1'b0, 1'b0));
    $display("break and gating done");
    cfg(8'h00, 8'hC1);
    apb(1'b1, uam_pkg::IDX_TXD, 8'h3C);
    rx_get(8'h3C, 5'h11);
    cfg(8'h00, 8'h00);
    uam_remote_node_inst.send(frame(8'h55, 1'b0, 1'b0), 10);
    none();
    apb(1'b1, uam_pkg::IDX_ADDR, 8'h5A);
    // Parity left off in multinode
    cfg(8'hC0, 8'h40);
    uam_remote_node_inst.send(frame(8'h33, 1'b1, 1'b1), 11);
    none();
    uam_remote_node_inst.send(frame(8'h11, 1'b1, 1'b0), 11);
    none();
    uam_remote_node_inst.send(frame(8'h5A, 1'b1, 1'b1), 11);
    rx_get(8'h5A, 5'h11);
    uam_remote_node_inst.send(frame(8'h77, 1'b1, 1'b0), 11);
    rx_get(8'h77, 5'h11);
    cfg(8'h10, 8'h50);
    uam_remote_node_inst.send(frame(8'h0F, 1'b1, 1'b0), 11);
    rx_get(8'h0F, 5'h01);
    uam_remote_node_inst.send(frame(8'h0F, 1'b1, 1'b1), 11);
    rx_get(8'h0F, 5'h13);
    $display("receive modes done");
    report_and_stop();
  end
endmodule
